// File: logic/wsbi_defines.svh
`ifndef WSBI_DEFINES_SVH
`define WSBI_DEFINES_SVH

// ----------------------------------------------------------------
// Bus cycle timing, in CPU clock periods
// ----------------------------------------------------------------
`define WSBI_ADDR_LAST    4'h1
`define WSBI_STROBE_STD   4'h3
`define WSBI_STROBE_LONG  4'hF
`define WSBI_CYCLE_STD    5'h06
`define WSBI_CYCLE_EXTRA  5'h0C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WSBI_HBR_RESET    8'h00
`define WSBI_BYTE_ZERO    8'h00

`endif

// File: logic/wsbi_pkg.sv
package wsbi_pkg;

    // Bus cycle sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_STROBE,
        ST_FINISH
    } wsbi_state_type;

    // Addressing form of the external data move
    typedef enum logic {
        MODE_REG_INDIRECT_8,
        MODE_POINTER_16
    } wsbi_mode_type;

endpackage : wsbi_pkg

// File: logic/wsbi_rsp_buf.sv
`timescale 1ns/1ps

module wsbi_rsp_buf #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    logic [WIDTH-1:0] head_r;
    logic [WIDTH-1:0] tail_r;
    logic             head_vld_r;
    logic             tail_vld_r;
    logic [WIDTH-1:0] head_nxt;
    logic [WIDTH-1:0] tail_nxt;
    logic             head_vld_nxt;
    logic             tail_vld_nxt;
    logic             pop;
    logic             push;

    // ------------------------------------------------------------
    // Two-entry skid: head feeds the output, tail catches overflow
    // ------------------------------------------------------------
    assign pop  = head_vld_r & out_ready;
    assign push = in_valid & ~tail_vld_r;

    // Next contents
    always_comb
    begin
        head_nxt     = head_r;
        tail_nxt     = tail_r;
        head_vld_nxt = head_vld_r & ~pop;
        tail_vld_nxt = tail_vld_r;
        if (pop && tail_vld_r)
        begin
            head_nxt     = tail_r;
            head_vld_nxt = 1'b1;
            tail_vld_nxt = 1'b0;
        end
        if (push)
        begin
            if (!head_vld_nxt)
            begin
                head_nxt     = in_data;
                head_vld_nxt = 1'b1;
            end
            else
            begin
                tail_nxt     = in_data;
                tail_vld_nxt = 1'b1;
            end
        end
    end

    // Storage
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            head_r     <= '0;
            tail_r     <= '0;
            head_vld_r <= 1'b0;
            tail_vld_r <= 1'b0;
        end
        else
        begin
            head_r     <= head_nxt;
            tail_r     <= tail_nxt;
            head_vld_r <= head_vld_nxt;
            tail_vld_r <= tail_vld_nxt;
        end
    end

    assign in_ready  = ~tail_vld_r;
    assign out_valid = head_vld_r;
    assign out_data  = head_r;

    // Full buffer refuses input
    no_overrun_a: assert property (@(posedge clk) disable iff (!nrst) // R5
        tail_vld_r && !out_ready |=> tail_vld_r && $stable(tail_r))
        else $error("buffer tail overwritten while full");

endmodule : wsbi_rsp_buf

// File: logic/wsbi_bus_ctrl.sv
// Function
// [R1] With the wide bus enabled every external data move, read or write, is a 16-bit transfer.
// [R2] In wide mode the low port carries the low address byte, then the low data byte.
// [R3] In wide mode the high port carries the high address byte, then the high data byte.
// [R4] A wide write drives the low byte from the accumulator and the high byte from the holder.
// [R5] A wide read returns the low byte to the accumulator and loads the high byte into the holder.
// [R6] Each wide bus cycle lasts six CPU clock periods; the code takes 18 when the cycle-stretch bit is set.
// [R7] The cycle-stretch bit widens the read and write strobes from 3 to 15 clock periods.
// [R8] A register-indirect 8-bit move drives the special function byte on the high port.
// [R9] A 16-bit pointer move with page access enabled drives the special function byte on high.
// [R10] Address latch enable marks a valid address on the low address/data lines.
// [R11] An active-low read strobe is output for external data reads.
// [R12] An active-low write strobe is output for external data writes.
// [R13] The storage device uses the read strobe as its I/O read and the write strobe as I/O write.
// [R14] The holder supplies the high byte of a write when preloaded and keeps the byte read back.
// [R15] Address and latch pulse come before the strobe, then address is released for data.
`timescale 1ns/1ps
`include "wsbi_defines.svh"

module wsbi_bus_ctrl (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Mode controls
    input  wire logic                  wide_bus_enable,
    input  wire logic                  cycle_stretch_bit,
    input  wire logic                  page_access_enable,
    // External data move request
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire logic                  req_write,
    input  wire wsbi_pkg::wsbi_mode_type req_mode,
    input  wire logic [15:0]           req_addr,
    input  wire logic [7:0]            accumulator,
    input  wire logic [7:0]            sfr_byte,
    // High-byte holding register
    input  wire logic                  hbr_load,
    input  wire logic [7:0]            hbr_wdata,
    output logic [7:0]                 high_byte_holding_register,
    // Read answers
    output logic                       rsp_valid,
    input  wire logic                  rsp_ready,
    output logic [15:0]                rsp_data,
    // Low multiplexed port
    input  wire logic [7:0]            low_address_data_lines_in,
    output logic [7:0]                 low_address_data_lines_out,
    output logic                       low_address_data_lines_oe,
    // High multiplexed port
    input  wire logic [7:0]            high_address_data_lines_in,
    output logic [7:0]                 high_address_data_lines_out,
    output logic                       high_address_data_lines_oe,
    // Strobes
    output logic                       ale,
    output logic                       rd_n,
    output logic                       wr_n
);

    import wsbi_pkg::*;

    wsbi_state_type state_r;
    wsbi_state_type state_nxt;
    logic [3:0]     cnt_r;
    logic [3:0]     cnt_nxt;
    logic           accept;
    logic           wr_r;
    logic           wide_r;
    logic           stretch_r;
    wsbi_mode_type  mode_r;
    logic           page_r;
    logic [7:0]     addr_lo_r;
    logic [7:0]     addr_hi_r;
    logic [15:0]    wdata_r;
    logic [15:0]    capt_r;
    logic [7:0]     hbr_r;
    logic [7:0]     p0_s1_r;
    logic [7:0]     p0_s2_r;
    logic [7:0]     p2_s1_r;
    logic [7:0]     p2_s2_r;
    logic           buf_in_ready;
    logic           buf_push;
    logic           req_ready_r;
    logic           ale_r;
    logic           rd_n_r;
    logic           wr_n_r;
    logic [7:0]     p0_out_r;
    logic [7:0]     p2_out_r;
    logic           p0_oe_r;
    logic           p2_oe_r;
    logic           ale_nxt;
    logic           rd_n_nxt;
    logic           wr_n_nxt;
    logic [7:0]     p0_out_nxt;
    logic [7:0]     p2_out_nxt;
    logic           p0_oe_nxt;
    logic           p2_oe_nxt;
    logic           s_wr;
    logic           s_wide;
    logic [7:0]     s_lo;
    logic [7:0]     s_hi;
    logic [15:0]    s_wdata;
    logic [3:0]     stb_len_r;
    logic [4:0]     cyc_cnt_r;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Last strobe count index for the selected width
    function automatic logic [3:0] strobe_last(input logic stretch);
        strobe_last = (stretch ? `WSBI_STROBE_LONG : `WSBI_STROBE_STD) - 4'h1;
    endfunction : strobe_last

    // High address byte source
    function automatic logic [7:0] high_addr(input wsbi_mode_type mode, input logic page,
                                             input logic [7:0] sfr, input logic [7:0] ptr_hi);
        high_addr = (mode == MODE_REG_INDIRECT_8 || page) ? sfr : ptr_hi;
    endfunction : high_addr

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            p0_s1_r <= `WSBI_BYTE_ZERO;
            p0_s2_r <= `WSBI_BYTE_ZERO;
            p2_s1_r <= `WSBI_BYTE_ZERO;
            p2_s2_r <= `WSBI_BYTE_ZERO;
        end
        else
        begin
            p0_s1_r <= low_address_data_lines_in;
            p0_s2_r <= p0_s1_r;
            p2_s1_r <= high_address_data_lines_in;
            p2_s2_r <= p2_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    assign accept   = req_valid & req_ready_r;
    assign buf_push = (state_r == ST_FINISH) & ~wr_r & buf_in_ready;

    // Next state and phase counter
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 4'h1;
        case (state_r)
            ST_IDLE:
            begin
                cnt_nxt = 4'h0;
                if (accept)
                    state_nxt = ST_ADDR;
            end
            ST_ADDR:
            begin
                if (cnt_r == `WSBI_ADDR_LAST)
                begin
                    state_nxt = ST_STROBE;
                    cnt_nxt   = 4'h0;
                end
            end
            ST_STROBE:
            begin
                if (cnt_r == strobe_last(stretch_r)) // R7 R6
                begin
                    state_nxt = ST_FINISH;
                    cnt_nxt   = 4'h0;
                end
            end
            ST_FINISH:
            begin
                cnt_nxt = 4'h0;
                if (wr_r || buf_in_ready)
                    state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
                cnt_nxt   = 4'h0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Request capture at acceptance
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_r      <= 1'b0;
            wide_r    <= 1'b0;
            stretch_r <= 1'b0;
            mode_r    <= MODE_REG_INDIRECT_8;
            page_r    <= 1'b0;
            addr_lo_r <= `WSBI_BYTE_ZERO;
            addr_hi_r <= `WSBI_BYTE_ZERO;
            wdata_r   <= 16'h0000;
        end
        else if (accept)
        begin
            wr_r      <= req_write;
            wide_r    <= wide_bus_enable;
            stretch_r <= cycle_stretch_bit;
            mode_r    <= req_mode;
            page_r    <= page_access_enable;
            addr_lo_r <= s_lo;
            addr_hi_r <= s_hi;
            wdata_r   <= s_wdata;
        end
    end

    // Ready only while idle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            req_ready_r <= 1'b0;
        else
            req_ready_r <= (state_nxt == ST_IDLE);
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    assign s_wr      = accept ? req_write : wr_r;
    assign s_wide    = accept ? wide_bus_enable : wide_r;
    assign s_lo      = accept ? req_addr[7:0] : addr_lo_r;
    assign s_hi      = accept ? high_addr(req_mode, page_access_enable, sfr_byte,
                                          req_addr[15:8]) : addr_hi_r; // R8 R9
    assign s_wdata   = accept ? {hbr_r, accumulator} : wdata_r; // R4 R14

    // Next pin levels follow the next state
    always_comb
    begin
        ale_nxt    = 1'b0;
        rd_n_nxt   = 1'b1;
        wr_n_nxt   = 1'b1;
        p0_out_nxt = s_lo;
        p2_out_nxt = s_hi;
        p0_oe_nxt  = 1'b0;
        p2_oe_nxt  = 1'b0;
        case (state_nxt)
            ST_ADDR:
            begin
                ale_nxt   = (cnt_nxt == 4'h0); // R10 R15
                p0_oe_nxt = 1'b1; // R2
                p2_oe_nxt = 1'b1; // R3
            end
            ST_STROBE, ST_FINISH:
            begin
                rd_n_nxt  = ~((state_nxt == ST_STROBE) & ~s_wr); // R11 R13
                wr_n_nxt  = ~((state_nxt == ST_STROBE) & s_wr); // R12 R13
                p2_oe_nxt = s_wr | ~s_wide; // R1
                p0_oe_nxt = s_wr; // R15
                if (s_wr)
                begin
                    p0_out_nxt = s_wdata[7:0]; // R4
                    if (s_wide)
                        p2_out_nxt = s_wdata[15:8]; // R3 R4
                end
            end
            default:
            begin
                ale_nxt = 1'b0;
            end
        endcase
    end

    // Pin registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ale_r    <= 1'b0;
            rd_n_r   <= 1'b1;
            wr_n_r   <= 1'b1;
            p0_out_r <= `WSBI_BYTE_ZERO;
            p2_out_r <= `WSBI_BYTE_ZERO;
            p0_oe_r  <= 1'b0;
            p2_oe_r  <= 1'b0;
        end
        else
        begin
            ale_r    <= ale_nxt;
            rd_n_r   <= rd_n_nxt;
            wr_n_r   <= wr_n_nxt;
            p0_out_r <= p0_out_nxt;
            p2_out_r <= p2_out_nxt;
            p0_oe_r  <= p0_oe_nxt;
            p2_oe_r  <= p2_oe_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data and holding register
    // ------------------------------------------------------------
    // Sample at the end of the read strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            capt_r <= 16'h0000;
        else if (state_r == ST_STROBE && state_nxt == ST_FINISH && !wr_r)
            capt_r <= {(wide_r ? p2_s2_r : `WSBI_BYTE_ZERO), p0_s2_r}; // R5 R2 R3
    end

    // Capture from a wide read wins over a software load
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            hbr_r <= `WSBI_HBR_RESET;
        else if (state_r == ST_STROBE && state_nxt == ST_FINISH && !wr_r && wide_r)
            hbr_r <= p2_s2_r; // R5 R14
        else if (hbr_load)
            hbr_r <= hbr_wdata; // R14
    end

    // Answer buffer, stalls the finish phase when full
    wsbi_rsp_buf #(
        .WIDTH (16)
    ) u_rsp_buf (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (buf_push),
        .in_ready  (buf_in_ready),
        .in_data   (capt_r),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready),
        .out_data  (rsp_data)
    );

    assign req_ready                   = req_ready_r;
    assign ale                         = ale_r;
    assign rd_n                        = rd_n_r;
    assign wr_n                        = wr_n_r;
    assign low_address_data_lines_out  = p0_out_r;
    assign low_address_data_lines_oe   = p0_oe_r;
    assign high_address_data_lines_out = p2_out_r;
    assign high_address_data_lines_oe  = p2_oe_r;
    assign high_byte_holding_register  = hbr_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Strobe low length and bus cycle length counters
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stb_len_r <= 4'h0;
            cyc_cnt_r <= 5'h00;
        end
        else
        begin
            stb_len_r <= (rd_n_r & wr_n_r) ? 4'h0 : stb_len_r + 4'h1;
            cyc_cnt_r <= (state_r == ST_IDLE) ? 5'h00 : cyc_cnt_r + 5'h01;
        end
    end

    sequence addr_phase_s;
        ale_r && p0_oe_r ##1 !ale_r && rd_n_r && wr_n_r;
    endsequence

    sequence strobe_start_s;
        !(rd_n_r && wr_n_r);
    endsequence

    strobe_width_a: assert property (@(posedge clk) disable iff (!nrst) // R7
        $rose(rd_n_r && wr_n_r) |->
            stb_len_r == (stretch_r ? `WSBI_STROBE_LONG : `WSBI_STROBE_STD))
        else $error("strobe width wrong");

    ale_before_strobe_a: assert property (@(posedge clk) disable iff (!nrst) // R10
        addr_phase_s |=> strobe_start_s)
        else $error("strobe does not follow address phase");

    cycle_length_a: assert property (@(posedge clk) disable iff (!nrst) // R6
        (state_r == ST_FINISH && wr_r) |->
            cyc_cnt_r + 5'h01 == `WSBI_CYCLE_STD + (stretch_r ? `WSBI_CYCLE_EXTRA : 5'h00))
        else $error("wide cycle length wrong");

    write_data_a: assert property (@(posedge clk) disable iff (!nrst) // R4
        !wr_n_r && wide_r |-> p0_oe_r && p2_oe_r &&
            {p2_out_r, p0_out_r} == wdata_r)
        else $error("write data not on ports");

    read_release_a: assert property (@(posedge clk) disable iff (!nrst) // R15
        !rd_n_r |-> !p0_oe_r && (p2_oe_r == !wide_r))
        else $error("port still driven during read");

    hbr_capture_a: assert property (@(posedge clk) disable iff (!nrst) // R5
        (state_r == ST_STROBE && state_nxt == ST_FINISH && !wr_r && wide_r) |=>
            hbr_r == capt_r[15:8])
        else $error("high byte not captured");

    sfr_ri_a: assert property (@(posedge clk) disable iff (!nrst) // R8
        ale_r && mode_r == MODE_REG_INDIRECT_8 |-> p2_out_r == $past(sfr_byte))
        else $error("register-indirect high port not sfr");

    sfr_page_a: assert property (@(posedge clk) disable iff (!nrst) // R9
        ale_r && mode_r == MODE_POINTER_16 && page_r |-> p2_out_r == $past(sfr_byte))
        else $error("page mode high port not sfr");

    strobe_exclusive_a: assert property (@(posedge clk) disable iff (!nrst) // R11
        (rd_n_r || wr_n_r) && (wr_n_r || wr_r) && (rd_n_r || !wr_r))
        else $error("strobe kind mismatch");

endmodule : wsbi_bus_ctrl

// File: tb/wsbi_dev_model.sv
`timescale 1ns/1ps

module wsbi_dev_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Controller side of the bus
    input  wire logic [7:0]  lo_out,
    input  wire logic        lo_oe,
    input  wire logic [7:0]  hi_out,
    input  wire logic        hi_oe,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] rd_word,
    // Resolved wire levels
    output logic [7:0]       lo_wire,
    output logic [7:0]       hi_wire,
    // Observations
    output logic [15:0]      adr_r,
    output logic [15:0]      wr_word_r,
    output logic [4:0]       strb_len_r,
    output logic [4:0]       lead_r,
    output logic [4:0]       ale_gap_r
);
    logic [4:0] since_ale_r;
    logic [4:0] run_r;
    logic [7:0] last_lo_r;
    logic [7:0] last_hi_r;
    logic       strb;

    // Strobes used directly as I/O read and write commands
    assign strb = !rd_n || !wr_n;
    // Released lines show the device word while rd_n is low, else the inverse of their last level
    assign lo_wire = lo_oe ? lo_out : (!rd_n ? rd_word[7:0] : ~last_lo_r);
    assign hi_wire = hi_oe ? hi_out : (!rd_n ? rd_word[15:8] : ~last_hi_r);

    // Latch address, write word and strobe timing
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            since_ale_r <= 5'h00;
            run_r       <= 5'h00;
            last_lo_r   <= 8'h00;
            last_hi_r   <= 8'h00;
            adr_r       <= 16'h0000;
            wr_word_r   <= 16'h0000;
            strb_len_r  <= 5'h00;
            lead_r      <= 5'h00;
            ale_gap_r   <= 5'h00;
        end
        else
        begin
            since_ale_r <= ale ? 5'h01 : since_ale_r + 5'h01;
            last_lo_r   <= lo_wire;
            last_hi_r   <= hi_wire;
            if (ale)
            begin
                adr_r     <= {hi_wire, lo_wire};
                ale_gap_r <= since_ale_r;
            end
            if (!wr_n)
                wr_word_r <= {hi_wire, lo_wire};
            if (strb && run_r == 5'h00)
                lead_r <= since_ale_r;
            if (strb)
                run_r <= run_r + 5'h01;
            else if (run_r != 5'h00)
            begin
                strb_len_r <= run_r;
                run_r      <= 5'h00;
            end
        end
    end
endmodule : wsbi_dev_model

// File: tb/tb.sv
`timescale 1ns/1ps

`define CHK(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("MISMATCH %s expected %h seen %h", nm, e, g); \
        end \
    end

module tb;
    import wsbi_pkg::*;

    localparam logic [2:0] WIDE = 3'h4;
    localparam logic [2:0] STR  = 3'h2;
    localparam logic [2:0] PAGE = 3'h1;

    logic          clk = 1'b0;
    logic          nrst = 1'b0;
    logic          wide_bus_enable = 1'b0, cycle_stretch_bit = 1'b0, page_access_enable = 1'b0;
    logic          req_valid = 1'b0, req_write = 1'b0, hbr_load = 1'b0, rsp_ready = 1'b0;
    wsbi_mode_type req_mode = MODE_POINTER_16;
    logic [15:0]   req_addr = 16'h0000, rd_word = 16'h0000;
    logic [7:0]    accumulator = 8'h00, sfr_byte = 8'h00, hbr_wdata = 8'h00;
    logic          req_ready, rsp_valid, lo_oe, hi_oe, ale, rd_n, wr_n;
    logic [15:0]   rsp_data, adr, wr_word;
    logic [7:0]    holder, lo_out, hi_out, lo_wire, hi_wire;
    logic [4:0]    strb_len, lead, ale_gap;
    int            bad_count = 0, samples_checked = 0;

    // Clock
    always #12.5 clk = ~clk;

    wsbi_bus_ctrl i_dut (
        .clk(clk), .nrst(nrst),
        .wide_bus_enable(wide_bus_enable), .cycle_stretch_bit(cycle_stretch_bit),
        .page_access_enable(page_access_enable),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_mode(req_mode), .req_addr(req_addr), .accumulator(accumulator),
        .sfr_byte(sfr_byte), .hbr_load(hbr_load), .hbr_wdata(hbr_wdata),
        .high_byte_holding_register(holder),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
        .low_address_data_lines_in(lo_wire), .low_address_data_lines_out(lo_out),
        .low_address_data_lines_oe(lo_oe),
        .high_address_data_lines_in(hi_wire), .high_address_data_lines_out(hi_out),
        .high_address_data_lines_oe(hi_oe),
        .ale(ale), .rd_n(rd_n), .wr_n(wr_n)
    );

    wsbi_dev_model i_dev (
        .clk(clk), .nrst(nrst), .lo_out(lo_out), .lo_oe(lo_oe), .hi_out(hi_out),
        .hi_oe(hi_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .rd_word(rd_word),
        .lo_wire(lo_wire), .hi_wire(hi_wire), .adr_r(adr), .wr_word_r(wr_word),
        .strb_len_r(strb_len), .lead_r(lead), .ale_gap_r(ale_gap)
    );

    task automatic give_verdict;
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    task automatic time_out(input string nm);
        bad_count++;
        $display("MISMATCH %s expected done seen timeout", nm);
        give_verdict();
    endtask : time_out

    // Bounded wait for the sequencer to go idle
    task automatic wait_ready;
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 100)
            time_out("req_ready");
    endtask : wait_ready

    // Present one request and return after the taking edge
    task automatic do_req(input logic w, input wsbi_mode_type m, input logic [15:0] a,
                          input logic [2:0] cfg, input logic [7:0] acc,
                          input logic [7:0] sfr, input logic [15:0] rw);
        @(negedge clk);
        {wide_bus_enable, cycle_stretch_bit, page_access_enable} = cfg;
        req_write = w;
        req_mode = m;
        req_addr = a;
        accumulator = acc;
        sfr_byte = sfr;
        req_valid = 1'b1;
        wait_ready();
        // Device word changes only after the previous read has sampled
        rd_word = rw;
        @(posedge clk);
    endtask : do_req

    task automatic end_req;
        @(negedge clk);
        req_valid = 1'b0;
        wait_ready();
        @(negedge clk);
    endtask : end_req

    // Take read answers and compare them in order
    task automatic drain(input logic [15:0] w[$]);
        int n;
        n = 0;
        @(negedge clk);
        rsp_ready = 1'b1;
        while (w.size() != 0 && n < 100)
        begin
            if (rsp_valid === 1'b1)
            begin
                `CHK("rsp_data", w[0], rsp_data)
                void'(w.pop_front());
            end
            @(negedge clk);
            n++;
        end
        rsp_ready = 1'b0;
        if (n >= 100)
            time_out("rsp_valid");
    endtask : drain

    task automatic s_write_wide;
        @(negedge clk);
        hbr_load = 1'b1;
        hbr_wdata = 8'h5A;
        @(negedge clk);
        hbr_load = 1'b0;
        `CHK("holder", 8'h5A, holder)
        do_req(1'b1, MODE_POINTER_16, 16'h1234, WIDE, 8'hC3, 8'h00, 16'h0000);
        do_req(1'b1, MODE_POINTER_16, 16'h1235, WIDE, 8'h3C, 8'h00, 16'h0000);
        end_req();
        `CHK("wr_word", 16'h5A3C, wr_word)
        `CHK("address", 16'h1235, adr)
        `CHK("strobe_len", 5'h03, strb_len)
        `CHK("ale_lead", 5'h02, lead)
        `CHK("ale_period", 5'h07, ale_gap)
    endtask : s_write_wide

    task automatic s_write_stretch;
        do_req(1'b1, MODE_REG_INDIRECT_8, 16'h0099, WIDE | STR, 8'h11, 8'hA7, 16'h0000);
        do_req(1'b1, MODE_REG_INDIRECT_8, 16'h0099, WIDE | STR, 8'h22, 8'hA7, 16'h0000);
        end_req();
        `CHK("address", 16'hA799, adr)
        `CHK("strobe_len", 5'h0F, strb_len)
        `CHK("ale_period", 5'h13, ale_gap)
        `CHK("wr_word", 16'h5A22, wr_word)
    endtask : s_write_stretch

    task automatic s_read_page;
        do_req(1'b0, MODE_POINTER_16, 16'h4321, WIDE | PAGE, 8'h00, 8'h6E, 16'hBEEF);
        end_req();
        `CHK("address", 16'h6E21, adr)
        `CHK("strobe_len", 5'h03, strb_len)
        `CHK("ale_lead", 5'h02, lead)
        drain('{16'hBEEF});
        `CHK("holder", 8'hBE, holder)
    endtask : s_read_page

    task automatic s_read_narrow;
        do_req(1'b0, MODE_POINTER_16, 16'h8001, 3'h0, 8'h00, 8'h6E, 16'h1357);
        end_req();
        `CHK("address", 16'h8001, adr)
        drain('{16'h0057});
        `CHK("holder", 8'hBE, holder)
    endtask : s_read_narrow

    task automatic s_read_stall;
        do_req(1'b0, MODE_POINTER_16, 16'h0010, WIDE, 8'h00, 8'h00, 16'h1111);
        do_req(1'b0, MODE_POINTER_16, 16'h0012, WIDE, 8'h00, 8'h00, 16'h2222);
        do_req(1'b0, MODE_POINTER_16, 16'h0014, WIDE, 8'h00, 8'h00, 16'h3333);
        @(negedge clk);
        req_valid = 1'b0;
        repeat (25) @(negedge clk);
        `CHK("req_ready", 1'b0, req_ready)
        `CHK("rd_n", 1'b1, rd_n)
        `CHK("holder", 8'h33, holder)
        drain('{16'h1111, 16'h2222, 16'h3333});
        wait_ready();
    endtask : s_read_stall

    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        `CHK("rd_n", 1'b1, rd_n)
        `CHK("wr_n", 1'b1, wr_n)
        `CHK("holder", 8'h00, holder)
        s_write_wide();
        s_write_stretch();
        s_read_page();
        s_read_narrow();
        s_read_stall();
        give_verdict();
    end
endmodule : tb
